// file: hdl/pot_tap_pkg.sv
// shared constants and carrier types for the coarse potentiometer tap encoder
package pot_tap_pkg;
  localparam int TAP_COUNT = 100;
  localparam int SEG_LEN = 25;
  localparam int POS_W = 8;
  localparam int CODE_W = 8;
  localparam logic [7:0] SEG1_BASE = 8'h19; // 25
  localparam logic [7:0] SEG2_BASE = 8'h32; // 50
  localparam logic [7:0] SEG3_BASE = 8'h4B; // 75
  localparam logic [7:0] MAX_POS = 8'h63; // 99
  localparam logic [7:0] SEG1_SUB = 8'h51; // 81
  localparam logic [7:0] SEG2_ADD = 8'h0E; // 14
  localparam logic [7:0] SEG3_SUB = 8'hC3; // 195
  localparam logic [7:0] CODE_RESET = 8'h00;
  // timing, in real time units, scaled to clock cycles below
  localparam int CLK_MHZ = 125;
  localparam int RECALL_MIN_MS = 25;
  localparam int RECALL_TYP_MS = 50;
  localparam int RECALL_MAX_MS = 75;
  localparam int SETTLE_MAX_US = 200;
  localparam int RECALL_TYP_CYC = RECALL_TYP_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_MAX_CYC = SETTLE_MAX_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // a tap request from host logic
  typedef struct packed {
    logic valid;
    logic signed [8:0] pos;
  } tap_req_s;

  // wiper data byte towards the wiper register
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } wiper_out_s;
endpackage

// file: hdl/tap_code_map.sv
// combinational tap position to wiper data byte translation
`timescale 1ns/1ps
module tap_code_map
  import pot_tap_pkg::*;
(
  // clamped tap position in
  input wire logic [7:0] pos,
  // wiper data byte out
  output logic [7:0] code
);
  // piecewise mapping over four segments
  always_comb
  begin
    if (pos >= SEG3_BASE)
      code = 8'(SEG3_SUB - pos);
    else if (pos >= SEG2_BASE)
      code = 8'(pos + SEG2_ADD);
    else if (pos >= SEG1_BASE)
      code = 8'(SEG1_SUB - pos);
    else
      code = pos;
  end
endmodule // tap_code_map

// file: hdl/pot_tap_code_encoder.sv
// tap encoder with power-up recall delay and wiper settle tracking
`timescale 1ns/1ps
// How it works
// - hundred taps, each a distinct byte
// - taps 0..24 map to themselves
// - taps 25..49 give 81 minus tap
// - taps 50..74 give tap plus 14
// - taps 75..99 give 195 minus tap
// - restore stored setting after recall delay
// - wiper settles within 200 us
module pot_tap_code_encoder
  import pot_tap_pkg::*;
#(
  parameter int RECALL_CYCLES = RECALL_TYP_CYC,
  parameter int SETTLE_CYCLES = SETTLE_MAX_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // supply monitor: high once supply is above recall_supply_threshold
  input wire logic supply_ok,
  // stored setting recalled at power-up
  input wire logic [7:0] stored_pos,
  // tap request
  input wire tap_req_s req,
  // wiper data byte and status
  output wiper_out_s wiper,
  output logic recall_done,
  output logic wiper_settling
);
  // refuse counter loads that the counter width cannot hold;
  // a zero load would wrap and take the whole counter range to reach the terminal count of one
  if (RECALL_CYCLES < 1 || RECALL_CYCLES >= (1 << CNT_W))
  begin : g_bad_recall
    $error("RECALL_CYCLES out of range");
  end

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W))
  begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end

  // sequencer states:
  // st_off    - supply below recall_supply_threshold, wiper left alone
  // st_recall - supply good, counting out powerup_recall_delay
  // st_run    - stored setting restored, host requests accepted
  typedef enum logic [1:0] {st_off, st_recall, st_run} state_e;

  // count down by one; both timers share this step
  function automatic logic [CNT_W-1:0] dec_cnt(input logic [CNT_W-1:0] v);
    dec_cnt = CNT_W'(v - CNT_W'(1));
  endfunction

  // clamp a signed request into 0..99
  // the host may hand over any signed value; anything outside the
  // tap range is pulled to the nearest end so that the map below
  // never sees a position that it has no code for
  function automatic logic [7:0] clamp_pos(input logic signed [8:0] p);
    if (p < 0)
      clamp_pos = 8'h00;
    else if (p > $signed({1'b0, MAX_POS}))
      clamp_pos = MAX_POS;
    else
      clamp_pos = p[7:0];
  endfunction

  // sequencer state
  state_e state;
  state_e next_state;
  // powerup_recall_delay and wiper_settle_time counters
  logic [CNT_W-1:0] recall_cnt;
  logic [CNT_W-1:0] next_recall_cnt;
  logic [CNT_W-1:0] settle_cnt;
  logic [CNT_W-1:0] next_settle_cnt;
  // translator in and out
  logic [7:0] map_pos;
  logic [7:0] map_code;
  // next values of the registered outputs
  wiper_out_s next_wiper;
  logic next_recall_done;
  logic next_wiper_settling;

  // choose the position to translate: recalled value or host request
  // while not running only the stored setting matters, so the
  // translator output is ready when the recall counter expires
  always_comb
  begin
    if (state == st_run)
      map_pos = clamp_pos(req.pos);
    else
      map_pos = clamp_pos($signed({1'b0, stored_pos}));
  end

  // one shared translator serves both recall and host requests
  tap_code_map u_map (
    .pos(map_pos),
    .code(map_code)
  );

  // recall sequencing, request acceptance and settle window
  // every register holds by default; wiper.valid is a one-cycle
  // strobe and drops unless a new code is loaded this cycle
  // the settle window runs on its own once started and is
  // restarted by every new code, so back-to-back requests keep
  // wiper_settling high until the last one has had its full time
  always_comb
  begin
    next_state = state;
    next_recall_cnt = recall_cnt;
    next_settle_cnt = settle_cnt;
    next_wiper = wiper;
    next_wiper.valid = 1'b0;
    next_recall_done = recall_done;
    next_wiper_settling = wiper_settling;
    if (wiper_settling)
    begin
      if (settle_cnt == CNT_W'(1))
        next_wiper_settling = 1'b0;
      next_settle_cnt = dec_cnt(settle_cnt);
    end

    case (state)
      // wait for the supply to come good, then arm the recall timer
      st_off:
      begin
        next_recall_done = 1'b0;
        if (supply_ok)
        begin
          next_state = st_recall;
          next_recall_cnt = CNT_W'(RECALL_CYCLES);
        end
      end
      // count out the recall delay; a supply dip starts it over
      st_recall:
      begin
        if (!supply_ok)
          next_state = st_off;
        else if (recall_cnt == CNT_W'(1))
        begin
          next_state = st_run;
          next_recall_done = 1'b1;
          next_wiper.valid = 1'b1;
          next_wiper.code = map_code;
          next_wiper_settling = 1'b1;
          next_settle_cnt = CNT_W'(SETTLE_CYCLES);
        end
        else
          next_recall_cnt = dec_cnt(recall_cnt);
      end

      // normal operation: each valid request loads a fresh code;
      // requests are simply dropped outside this state
      st_run:
      begin
        if (!supply_ok)
        begin
          next_state = st_off;
          next_recall_done = 1'b0;
        end
        else if (req.valid)
        begin
          next_wiper.valid = 1'b1;
          next_wiper.code = map_code;
          next_wiper_settling = 1'b1;
          next_settle_cnt = CNT_W'(SETTLE_CYCLES);
        end
      end

      // an unused encoding falls back to the safe off state
      default:
        next_state = st_off;
    endcase
  end

  // state registers
  // reset leaves the wiper code at zero with no strobe, and the
  // sequencer off, so a fresh recall follows the release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_off;
      recall_cnt <= '0;
      settle_cnt <= '0;
      wiper <= '{valid: 1'b0, code: CODE_RESET};
      recall_done <= 1'b0;
      wiper_settling <= 1'b0;
    end
    else
    begin
      state <= next_state;
      recall_cnt <= next_recall_cnt;
      settle_cnt <= next_settle_cnt;
      wiper <= next_wiper;
      recall_done <= next_recall_done;
      wiper_settling <= next_wiper_settling;
    end
  end
endmodule // pot_tap_code_encoder

// file: verification/pot_tap_monitor.sv
// encoder checker
`timescale 1ns/1ps
module pot_tap_monitor
  import pot_tap_pkg::*;
#(parameter int RECALL_CYCLES = 20)
(
  // watched ports
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire tap_req_s req,
  input wire wiper_out_s wiper,
  input wire logic recall_done,
  input wire logic wiper_settling
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // shorthands
  wire t = req.valid && recall_done && supply_ok;
  wire signed [8:0] q = req.pos;
  wire [7:0] c = wiper.code;
  a_code_ok: assert property (wiper.valid |-> c inside {[0:24],[32:56],[64:88],[96:120]})
    else $error("code");
  a_seg_zero: assert property (t && q inside {[0:24]} |=> c == $past(q))
    else $error("s0");
  a_seg_one: assert property (t && q inside {[25:49]} |=> c == 8'h51 - $past(q))
    else $error("s1");
  a_seg_two: assert property (t && q inside {[50:74]} |=> c == 8'h0E + $past(q))
    else $error("s2");
  a_seg_three: assert property (t && q inside {[75:99]} |=> c == 8'hC3 - $past(q))
    else $error("s3");
  a_recall_wait: assert property ($rose(recall_done) |-> wiper.valid &&
    $past(supply_ok, RECALL_CYCLES)) else $error("rc");
  a_settle_hold: assert property (wiper.valid |-> wiper_settling[*8])
    else $error("st");
  a_clamp_end: assert property (t && (q < 0 || q > 99) |=>
    c == ($past(q[8]) ? 8'h00 : 8'h60)) else $error("cl");
endmodule // pot_tap_monitor

// file: verification/pot_host_model.sv
// host request model
`timescale 1ns/1ps
module pot_host_model
  import pot_tap_pkg::*;
(
  // clock in, request out
  input wire logic ref_clk,
  output tap_req_s req = '0
);
  // pulse from a falling edge, position scrambled after
  task automatic send(logic signed [8:0] pos);
    @(negedge ref_clk);
    req <= {1'b1, pos};
    @(negedge ref_clk);
    req <= {1'b0, ~pos};
  endtask
endmodule // pot_host_model

// file: verification/pot_tap_code_encoder_tb.sv
// tap encoder bench
`timescale 1ns/1ps
module pot_tap_code_encoder_tb
  import pot_tap_pkg::*;
  ;
  logic ref_clk = 0, rst = 1, supply_ok = 1;
  logic [7:0] stored_pos = 8'hC8;
  logic recall_done, wiper_settling;
  tap_req_s req;
  wiper_out_s wiper;
  int failures = 0, n_tests = 0;
  pot_host_model u_pot_host_model (.ref_clk(ref_clk), .req(req));
  pot_tap_code_encoder #(.RECALL_CYCLES(20), .SETTLE_CYCLES(8)) u_pot_tap_code_encoder (
    .ref_clk(ref_clk), .rst(rst), .supply_ok(supply_ok), .stored_pos(stored_pos),
    .req(req), .wiper(wiper), .recall_done(recall_done), .wiper_settling(wiper_settling));
  // clock
  initial forever #4 ref_clk = ~ref_clk;
  // compare and count
  task automatic chk(string s, logic [8:0] v, e);
    n_tests++;
    if (v !== e)
    begin
      failures++;
      $display("wrong value %s %h %h", s, e, v);
    end
  endtask
  // verdict
  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // recall of an out-of-range stored tap, then every tap and some beyond
  task automatic t_sweep;
    int c;
    c = 0;
    while (recall_done !== 1'b1 && c < 40) @(negedge ref_clk) c++;
    chk("recall", {wiper.valid, wiper.code}, 9'h160);
    for (int p = -2; p < 102; p++)
    begin
      c = p < 0 ? 0 : p > 99 ? 96 : p < 25 ? p : p < 50 ? 81 - p : p < 75 ? p + 14 : 195 - p;
      u_pot_host_model.send(9'(p));
      chk("code", {wiper.valid, wiper.code}, {1'b1, 8'(c)});
    end
  endtask
  // settle window length after one request
  task automatic t_settle;
    u_pot_host_model.send(9'h00A);
    chk("settle start", {1'b0, wiper_settling}, 9'h001);
    repeat (7) @(negedge ref_clk);
    chk("settle held", {1'b0, wiper_settling}, 9'h001);
    @(negedge ref_clk);
    chk("settle end", {1'b0, wiper_settling}, 9'h000);
  endtask
  // supply loss drops requests, then a full recall of a new stored tap
  task automatic t_power;
    int c;
    c = 0;
    supply_ok = 1'b0;
    @(negedge ref_clk);
    chk("done low", {8'h00, recall_done}, 9'h000);
    u_pot_host_model.send(9'h005);
    chk("refused", {wiper.valid, wiper.code}, 9'h00A);
    stored_pos = 8'h2A;
    supply_ok = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("recall early", {8'h00, recall_done}, 9'h000);
    while (recall_done !== 1'b1 && c < 40) @(negedge ref_clk) c++;
    chk("recall again", {wiper.valid, wiper.code}, 9'h127);
    chk("recall settle", {1'b0, wiper_settling}, 9'h001);
  endtask
  // reset, then the scenario
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rst = 0;
    t_sweep;
    t_settle;
    t_power;
    report_and_stop;
  end
  // hang guard, well beyond the few hundred cycles the scenarios need
  initial
  begin
    #20000;
    failures++;
    report_and_stop;
  end
endmodule // pot_tap_code_encoder_tb
bind pot_tap_code_encoder pot_tap_monitor #(.RECALL_CYCLES(RECALL_CYCLES)) u_pot_tap_monitor (
  .ref_clk(ref_clk), .rst(rst), .supply_ok(supply_ok), .req(req), .wiper(wiper),
  .recall_done(recall_done), .wiper_settling(wiper_settling));
